// ---- inc/smc_consts.svh ----
// Constants for the static memory port: widths, strobe phase lengths, encodings
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

`define SMC_ADDR_W      25
`define SMC_DATA_W      16
`define SMC_BANKS       4
`define SMC_BANK_W      2
`define SMC_LANES       2
`define SMC_CNT_W       4
// Phase lengths in ref_clk cycles (one cycle is 20 ns)
`define SMC_SETUP_CYC   4'h2
`define SMC_ACCESS_CYC  4'h4
`define SMC_HOLD_CYC    4'h1
`define SMC_CNT_ONE     4'h1
`define SMC_CNT_ZERO    4'h0
`define SMC_ADDR_IDLE   25'h0000000
`define SMC_DATA_IDLE   16'h0000
`define SMC_LANES_NONE  2'h3
`define SMC_BANKS_NONE  4'hf
`define SMC_LANE_LO     2'h1
`define SMC_LANE_HI     2'h2
`define SMC_LANE_BOTH   2'h3

`endif

// ---- inc/smc_pkg.sv ----
// Types shared by the static memory port design
package smc_pkg;

    // Access request from the internal side
    typedef struct packed {
        logic        write;
        logic [1:0]  bank;
        logic [24:0] addr;
        logic [1:0]  lanes;   // Active high: bit0 lower byte, bit1 upper byte
        logic [15:0] wdata;
    } smc_req_s;

    // External pin group, active-low strobes
    typedef struct packed {
        logic [24:0] ext_addr;
        logic [1:0]  byte_lane_sel_n;
        logic [3:0]  mem_bank_sel_n;
        logic        out_en_strobe_n;
        logic        rd_strobe_n;
        logic        wr_strobe_n;
    } smc_pins_s;

    // Access sequencer states, Gray coded along idle-setup-access-hold
    typedef enum logic [1:0] {
        SMC_IDLE   = 2'b00,
        SMC_SETUP  = 2'b01,
        SMC_ACCESS = 2'b11,
        SMC_HOLD   = 2'b10
    } smc_state_e;

endpackage

// ---- logic/smc_phase_timer.sv ----
// Down-counter that times each phase of an external access
`timescale 1ns/1ps
`include "smc_consts.svh"

module smc_phase_timer (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // Control
    input  wire logic                  load,
    input  wire logic [`SMC_CNT_W-1:0] load_val,
    input  wire logic                  hold_off,
    // Status
    output logic                       last
);

    logic [`SMC_CNT_W-1:0] cnt_reg;

    // Count down; hold_off freezes the count so a slow memory can stretch
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= `SMC_CNT_ZERO;
        end else if (load) begin
            cnt_reg <= load_val;
        end else if (!hold_off && cnt_reg != `SMC_CNT_ZERO) begin
            cnt_reg <= cnt_reg - `SMC_CNT_ONE;
        end
    end

    // Last cycle of the phase; kept independent of load, which the sequencer
    // decodes from this very signal, so no combinational loop can form
    assign last = (cnt_reg == `SMC_CNT_ONE) && !hold_off;

endmodule

// ---- logic/smc_static_mem_ctrl.sv ----
// Asynchronous static memory port: sequences external reads and writes
`timescale 1ns/1ps
`include "smc_consts.svh"


module smc_static_mem_ctrl (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    // Internal request side
    input  wire logic                   req_valid,
    input  wire smc_pkg::smc_req_s      req,
    output logic                        req_ready,
    output logic                        rsp_valid,
    output logic [`SMC_DATA_W-1:0]      rsp_rdata,
    // External memory pins
    output smc_pkg::smc_pins_s          pins,
    input  wire logic                   ext_wait_ready,
    input  wire logic [`SMC_DATA_W-1:0] ext_data_i,
    output logic [`SMC_DATA_W-1:0]      ext_data_o,
    output logic                        ext_data_oe_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // One-hot active-low bank select
    function automatic logic [`SMC_BANKS-1:0] bank_dec(input logic [`SMC_BANK_W-1:0] b);
        logic [`SMC_BANKS-1:0] v;
        v = `SMC_BANKS_NONE;
        v[b] = 1'b0;
        return v;
    endfunction

    // Active-low byte-lane pattern from active-high lane request
    function automatic logic [`SMC_LANES-1:0] lane_dec(input logic [`SMC_LANES-1:0] l);
        logic [`SMC_LANES-1:0] v;
        v = `SMC_LANES_NONE;
        unique case (l)
            `SMC_LANE_LO: v = 2'b10;
            `SMC_LANE_HI: v = 2'b01;
            default: v = 2'b00;   // Both-lane and empty masks
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    smc_pkg::smc_state_e state_reg;
    smc_pkg::smc_state_e state_next;
    smc_pkg::smc_req_s   req_reg;
    logic                phase_load;
    logic [`SMC_CNT_W-1:0] phase_val;
    logic                phase_last;
    logic                take;

    assign req_ready = (state_reg == smc_pkg::SMC_IDLE);
    assign take      = req_valid && req_ready;

    // Next state; ready only gates the access phase
    always_comb begin
        state_next = state_reg;
        phase_load = 1'b0;
        phase_val  = `SMC_SETUP_CYC;
        unique case (state_reg)
            smc_pkg::SMC_IDLE: begin
                if (take) begin
                    state_next = smc_pkg::SMC_SETUP;
                    phase_load = 1'b1;
                    phase_val  = `SMC_SETUP_CYC;
                end
            end
            smc_pkg::SMC_SETUP: begin
                if (phase_last) begin
                    state_next = smc_pkg::SMC_ACCESS;
                    phase_load = 1'b1;
                    phase_val  = `SMC_ACCESS_CYC;
                end
            end
            smc_pkg::SMC_ACCESS: begin
                if (phase_last) begin
                    state_next = smc_pkg::SMC_HOLD;
                    phase_load = 1'b1;
                    phase_val  = `SMC_HOLD_CYC;
                end
            end
            smc_pkg::SMC_HOLD: begin
                if (phase_last) begin
                    state_next = smc_pkg::SMC_IDLE;
                end
            end
        endcase
    end

    smc_phase_timer u_timer (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .load     (phase_load),
        .load_val (phase_val),
        .hold_off ((state_reg == smc_pkg::SMC_ACCESS) && !ext_wait_ready),
        .last     (phase_last)
    );

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= smc_pkg::SMC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Latch the request so pins stay stable through the access
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_reg <= '0;
        end else if (take) begin
            req_reg <= req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive, registered so strobes never glitch

    logic in_access_next;
    assign in_access_next = (state_next != smc_pkg::SMC_IDLE);

    // Address, bank and lanes follow the next state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins.ext_addr        <= `SMC_ADDR_IDLE;
            pins.mem_bank_sel_n  <= `SMC_BANKS_NONE;
            pins.byte_lane_sel_n <= `SMC_LANES_NONE;
        end else if (in_access_next) begin
            pins.ext_addr        <= take ? req.addr : req_reg.addr;
            pins.mem_bank_sel_n  <= bank_dec(take ? req.bank : req_reg.bank);
            pins.byte_lane_sel_n <= (take ? req.write : req_reg.write)
                                    ? lane_dec(take ? req.lanes : req_reg.lanes)
                                    : `SMC_LANE_BOTH ^ `SMC_LANE_BOTH;
        end else begin
            pins.mem_bank_sel_n  <= `SMC_BANKS_NONE;
            pins.byte_lane_sel_n <= `SMC_LANES_NONE;
        end
    end

    // Read strobes: both open at setup start and close at hold
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins.out_en_strobe_n <= 1'b1;
            pins.rd_strobe_n     <= 1'b1;
        end else begin
            pins.out_en_strobe_n <= !((state_next == smc_pkg::SMC_SETUP ||
                                       state_next == smc_pkg::SMC_ACCESS) &&
                                      !(take ? req.write : req_reg.write));
            pins.rd_strobe_n     <= !((state_next == smc_pkg::SMC_SETUP ||
                                       state_next == smc_pkg::SMC_ACCESS) &&
                                      !(take ? req.write : req_reg.write));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins.wr_strobe_n <= 1'b1;
        end else begin
            pins.wr_strobe_n <= !(state_next == smc_pkg::SMC_ACCESS && req_reg.write);
        end
    end

    // drive data only from setup to hold of a write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_data_o    <= `SMC_DATA_IDLE;
            ext_data_oe_n <= 1'b1;
        end else if (in_access_next && (take ? req.write : req_reg.write)) begin
            ext_data_o    <= take ? req.wdata : req_reg.wdata;
            ext_data_oe_n <= 1'b0;
        end else begin
            ext_data_o    <= `SMC_DATA_IDLE;
            ext_data_oe_n <= 1'b1;
        end
    end

    // Capture read data on the last access cycle, while strobes still stand
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= `SMC_DATA_IDLE;
        end else begin
            rsp_valid <= (state_reg == smc_pkg::SMC_ACCESS) && phase_last;
            if ((state_reg == smc_pkg::SMC_ACCESS) && phase_last && !req_reg.write) begin
                rsp_rdata <= ext_data_i;
            end
        end
    end

endmodule

// ---- tb/smc_port_monitor.sv ----
// Checker for the static memory port pins
`timescale 1ns/1ps
module smc_port_monitor (
    // Clock and reset
    input wire logic               ref_clk,
    input wire logic               rst_n,
    // Request side
    input wire logic               req_valid,
    input wire smc_pkg::smc_req_s  req,
    input wire logic               req_ready,
    input wire logic               rsp_valid,
    // Memory pins
    input wire smc_pkg::smc_pins_s pins,
    input wire logic               ext_wait_ready,
    input wire logic               ext_data_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Request taken at this edge
    wire tk = req_valid && req_ready;
    ////////////////////////////////////////
    a_addr_driven: assert property (tk |=> pins.ext_addr == $past(req.addr))
        else $error("address not driven");
    a_bank_onehot: assert property (tk |=> pins.mem_bank_sel_n == ~(4'h1 << $past(req.bank)))
        else $error("bank select wrong");
    a_idle_quiet: assert property (req_ready |-> pins.mem_bank_sel_n == 4'hf &&
        pins.rd_strobe_n && pins.wr_strobe_n && ext_data_oe_n) else $error("idle not quiet");
    a_lane_write: assert property (tk && req.write |=> pins.byte_lane_sel_n ==
        ($past(req.lanes) == 2'h0 ? 2'h0 : ~$past(req.lanes))) else $error("lanes wrong");
    a_read_strobe: assert property (tk && !req.write |=>
        !pins.out_en_strobe_n && !pins.rd_strobe_n ##2 !pins.rd_strobe_n) else $error("rd strobe");
    a_write_window: assert property (tk && req.write |=>
        pins.wr_strobe_n [*2] ##1 !pins.wr_strobe_n) else $error("wr strobe late");
    a_strobe_end: assert property (rsp_valid |=> pins.wr_strobe_n && pins.rd_strobe_n)
        else $error("strobe not ended");
    a_ready_stall: assert property (!ext_wait_ready && !pins.wr_strobe_n |=>
        !pins.wr_strobe_n) else $error("moved on while not ready");
    a_rsp_latency: assert property (tk |=> !rsp_valid [*5] ##[1:12] rsp_valid)
        else $error("answer timing");
endmodule
bind smc_static_mem_ctrl smc_port_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .pins(pins), .ext_wait_ready(ext_wait_ready), .ext_data_oe_n(ext_data_oe_n));

// ---- tb/smc_sram_model.sv ----
// Behavioural static memory behind the port, with a settable stall
`timescale 1ns/1ps
module smc_sram_model (
    // Clock and stall control
    input wire logic               ref_clk,
    input wire logic [3:0]         stall_cyc,
    // Controller pins
    input wire smc_pkg::smc_pins_s pins,
    input wire logic [15:0]        ext_data_o,
    input wire logic               ext_data_oe_n,
    // Memory side
    output logic                   ext_wait_ready,
    output logic [15:0]            bus
);
    logic [15:0] mem [16];
    logic [15:0] junk = 16'h5a5a;
    logic [3:0]  wait_cnt = 4'h0;
    logic        sel_q = 1'h0;
    wire         sel = pins.mem_bank_sel_n != 4'hf;
    // Released bus toggles so a stale value never looks valid
    assign bus = !ext_data_oe_n ? ext_data_o :
                 (sel && !pins.out_en_strobe_n) ? mem[pins.ext_addr[3:0]] : junk;
    // Ready held low for stall_cyc cycles from the second setup cycle
    assign ext_wait_ready = wait_cnt == 4'h0;
    always @(posedge ref_clk) begin
        junk <= ~junk;
        sel_q <= sel;
        wait_cnt <= (sel && !sel_q) ? stall_cyc : wait_cnt - 4'(wait_cnt != 4'h0);
        if (sel && !pins.wr_strobe_n && !pins.byte_lane_sel_n[0])
            mem[pins.ext_addr[3:0]][7:0] <= bus[7:0];
        if (sel && !pins.wr_strobe_n && !pins.byte_lane_sel_n[1])
            mem[pins.ext_addr[3:0]][15:8] <= bus[15:8];
    end
endmodule

// ---- tb/async_static_memory_port_test.sv ----
// Self-checking bench for the static memory port
`timescale 1ns/1ps
module async_static_memory_port_test;
    logic              ref_clk = 1'h0;
    logic              rst_n = 1'h0;
    logic              req_valid = 1'h0;
    smc_pkg::smc_req_s req = '0;
    logic              req_ready, rsp_valid, ready, oe_n;
    logic [15:0]       rdata, bus, data_o, got;
    smc_pkg::smc_pins_s pins;
    logic [3:0]        stall_cyc = 4'h0;
    int                miscompares = 0;
    int                total_checks = 0;
    int                lat, lat0;
    always #10 ref_clk = ~ref_clk;
    smc_static_mem_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rdata),
        .pins(pins), .ext_wait_ready(ready), .ext_data_i(bus), .ext_data_o(data_o),
        .ext_data_oe_n(oe_n));
    smc_sram_model u_mem (.ref_clk(ref_clk), .stall_cyc(stall_cyc), .pins(pins),
        .ext_data_o(data_o), .ext_data_oe_n(oe_n), .ext_wait_ready(ready), .bus(bus));
    ////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bounded wait of one cycle; a hang ends the run as a failure
    task automatic tick(inout int n);
        @(posedge ref_clk);
        #1;
        if (++n > 40) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    // One access: held until taken, then pins checked while the answer stands
    task automatic acc(logic wr, logic [1:0] bk, logic [24:0] ad, logic [1:0] ln,
                       logic [15:0] wd);
        int n;
        logic [3:0] bs;
        logic [1:0] le;
        logic [2:0] se;
        n = 0;
        bs = ~(4'h1 << bk);
        le = wr ? (ln == 2'h1 ? 2'h2 : (ln == 2'h2 ? 2'h1 : 2'h0)) : 2'h0;
        se = wr ? 3'h7 : 3'h1;
        req = '{wr, bk, ad, ln, wd};
        req_valid = 1'h1;
        while (req_ready !== 1'h1) tick(n);
        tick(n);
        req_valid = 1'h0;
        // Setup cycle: read strobes open at once on a read, all strobes stay closed on a write, lanes already set
        chk("setup", {pins.out_en_strobe_n, pins.rd_strobe_n, pins.wr_strobe_n}, se);
        chk("lanes", pins.byte_lane_sel_n, le);
        lat = 0;
        tick(lat);
        tick(lat);
        // First access cycle: strobe of this kind stands, data driven on writes only
        chk("access strobes", {pins.rd_strobe_n, pins.wr_strobe_n}, wr ? 2'h2 : 2'h1);
        chk("data drive", oe_n, !wr);
        while (rsp_valid !== 1'h1) tick(lat);
        got = rdata;
        chk("addr", pins.ext_addr, ad);
        chk("bank", pins.mem_bank_sel_n, bs);
        // Answer stands in the hold cycle, after the strobes have closed
        chk("strobe end", {pins.rd_strobe_n, pins.wr_strobe_n}, 2'h3);
    endtask
    ////////////////////////////////////////
    task automatic t_word;
        acc(1'h1, 2'h0, 25'h3, 2'h3, 16'hc3a5);
        acc(1'h0, 2'h0, 25'h3, 2'h0, 16'h0);
        chk("word", got, 16'hc3a5);
        $display("test word done");
    endtask
    task automatic t_lanes;
        acc(1'h1, 2'h1, 25'h1ffff05, 2'h0, 16'h1234);
        acc(1'h1, 2'h1, 25'h1ffff05, 2'h2, 16'hab99);
        acc(1'h1, 2'h1, 25'h1ffff05, 2'h1, 16'h77cd);
        acc(1'h0, 2'h1, 25'h1ffff05, 2'h0, 16'h0);
        chk("lanes", got, 16'habcd);
        $display("test lanes done");
    endtask
    task automatic t_banks;
        for (int b = 0; b < 4; b++) begin
            acc(1'h0, 2'(b), 25'h3, 2'h0, 16'h0);
            chk("bank data", got, 16'hc3a5);
        end
        lat0 = lat;
        $display("test banks done");
    endtask
    task automatic t_stall;
        stall_cyc = 4'h7;
        acc(1'h0, 2'h2, 25'h3, 2'h0, 16'h0);
        chk("stall data", got, 16'hc3a5);
        chk("stall delay", lat > lat0, 1'h1);
        acc(1'h1, 2'h3, 25'h3, 2'h3, 16'h0ff0);
        stall_cyc = 4'h0;
        acc(1'h0, 2'h0, 25'h3, 2'h0, 16'h0);
        chk("stall write", got, 16'h0ff0);
        $display("test stall done");
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        #1;
        rst_n = 1'h1;
        t_word();
        t_lanes();
        t_banks();
        t_stall();
        tally_and_finish();
    end
endmodule
